// >>> design/charge_seq_regs.svh
/*
 * Timing counts and factory option encodings for the charge sequencer.
 * Assumes a 25 MHz clock; included by the sequencer and its timebase.
 */
`ifndef CHARGE_SEQ_REGS_SVH
`define CHARGE_SEQ_REGS_SVH

`define CLK_HZ 25000000
`define CLK_KHZ 25000
// timebase tick of 1 ms
`define TICK_MS 1
`define TICK_CYCLES (`CLK_KHZ * `TICK_MS)
// termination filter
`define EOC_FILTER_MS 1
`define EOC_FILTER_TICKS (`EOC_FILTER_MS / `TICK_MS)
// flash: 1.6 s period, 50% duty, half period in ms
`define FLASH_PERIOD_MS 1600
`define FLASH_HALF_TICKS (`FLASH_PERIOD_MS / 2 / `TICK_MS)
// preconditioning timer, minutes
`define PRECON_MIN 32
// safety timer options, hours
`define SAFETY_HR_0 4
`define SAFETY_HR_1 6
`define SAFETY_HR_2 8
`define MS_PER_MIN 60000
`define MS_PER_HR 3600000
// safety timer selection codes
`define TSEL_4H 2'h0
`define TSEL_6H 2'h1
`define TSEL_8H 2'h2
`define TSEL_OFF 2'h3

`endif

// >>> design/charge_seq_pkg.sv
/*
 * Types for the charge sequencer: state encoding and option selectors.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package charge_seq_pkg;

    typedef enum logic [3:0] {
        ST_SHUTDOWN = 4'h0,
        ST_STANDBY = 4'h1,
        ST_SHORT = 4'h2,
        ST_PRECON = 4'h3,
        ST_CC = 4'h4,
        ST_CV = 4'h5,
        ST_DONE = 4'h6,
        ST_TEMP_FAULT = 4'h7,
        ST_TIMER_FAULT = 4'h8,
        ST_PRE_FAULT = 4'h9
    } charge_state_t;

    // regulation voltage options 8.2, 8.4, 8.7, 8.8 V
    typedef enum logic [1:0] {
        VREG_8V2 = 2'h0,
        VREG_8V4 = 2'h1,
        VREG_8V7 = 2'h2,
        VREG_8V8 = 2'h3
    } vreg_sel_t;

    // end-of-charge ratio options 5, 7.5, 10, 20 percent
    typedef enum logic [1:0] {
        EOC_5 = 2'h0,
        EOC_7P5 = 2'h1,
        EOC_10 = 2'h2,
        EOC_20 = 2'h3
    } eoc_sel_t;

    // commanded current level for the analog pass device
    typedef enum logic [2:0] {
        CUR_OFF = 3'h0,
        CUR_SHORT = 3'h1,
        CUR_PRECON = 3'h2,
        CUR_FAST = 3'h3,
        CUR_CV = 3'h4
    } current_mode_t;

endpackage

// >>> design/charge_timebase.sv
/*
 * Free-running prescaler giving a one-cycle 1 ms tick and a flash phase
 * toggling every 0.8 s. Cleared by synchronous reset at power-up.
 */
`timescale 1ns/1ns
`include "charge_seq_regs.svh"

module charge_timebase (
    input wire logic clk,
    input wire logic rst_n,
    output logic msTick,
    output logic flashPhase
);
    logic [14:0] prescale;
    logic [9:0] flashCount;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prescale <= 15'h0000;
            msTick <= 1'b0;
        end else if (prescale == 15'(`TICK_CYCLES - 1)) begin
            prescale <= 15'h0000;
            msTick <= 1'b1;
        end else begin
            prescale <= prescale + 15'h0001;
            msTick <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flashCount <= 10'h000;
            flashPhase <= 1'b0;
        end else if (msTick) begin
            if (flashCount == 10'(`FLASH_HALF_TICKS - 1)) begin
                flashCount <= 10'h000;
                flashPhase <= ~flashPhase;
            end else begin
                flashCount <= flashCount + 10'h001;
            end
        end
    end
endmodule

// >>> design/charge_sequencer.sv
/*
 * Charge state machine for a linear two-cell charger: safety timers,
 * termination filter, recharge, thermal and short handling, status pin.
 * Assumes all comparator flags are synchronous to clk and already carry
 * the analog hysteresis; option straps are static after reset.
 */
// Operation
// RL1: entering fast charge restarts safety timer
// RL2: fast charge until regulation level reached
// RL3: timer expiry in fast charge faults
// RL4: timer fault held until battery removed
// RL5: regulation target is one of four
// RL6: CV ends on low current or timeout
// RL7: low-current flag must persist 1 ms
// RL8: safety timer period selectable, or disabled
// RL9: charge complete watches for recharge level
// RL10: no recharge option goes to standby
// RL11: restart needs removal, power or program cycle
// RL12: suspend above 150C, resume after cooling
// RL13: status pin only pulls low or releases
// RL14: status low while charging, else released
// RL15: faults flash 1.6 s or stay released
// RL16: hold short below 1.7 V, trickle only
// RL17: leave short hold above hysteresis level
// RL18: thermal regulation reduces commanded current
// RL19: precondition below threshold, then fast charge
// RL20: precondition timeout faults until removal
// RL21: open program pin holds standby
// RL22: shutdown on supply over or under voltage
// RL23: all timing from one shared timebase
// RL24: over-temperature shows temperature fault state
`timescale 1ns/1ns
`include "charge_seq_regs.svh"

module charge_sequencer
    import charge_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supplyOk,
    input wire logic batteryPresent,
    input wire logic programOpen,
    input wire logic belowShort,
    input wire logic aboveShortHyst,
    input wire logic belowPrecon,
    input wire logic atRegulation,
    input wire logic belowRecharge,
    input wire logic belowEocRatio,
    input wire logic dieHot,
    input wire logic dieCooled,
    input wire logic dieRegulating,
    input wire vreg_sel_t vregSel,
    input wire eoc_sel_t eocSel,
    input wire logic [1:0] safetyTimerSel,
    input wire logic preconEnable,
    input wire logic preconTimerEnable,
    input wire logic rechargeEnable,
    input wire logic flashType,
    output charge_state_t state,
    output current_mode_t currentMode,
    output logic thermalFoldback,
    output vreg_sel_t vregTarget,
    output eoc_sel_t eocTarget,
    output logic statusOut,
    output logic statusOe
);
    charge_state_t next_state;
    logic msTick;
    logic flashPhase;
    // the longest limit needs 25 bits
    logic [24:0] safetyMs;
    logic [21:0] preconMs;
    logic [3:0] eocMs;
    logic eocQualified;
    logic safetyExpired;
    logic preconExpired;
    logic latchedOff;
    logic prevProgramOpen;
    logic charging;

    // one shared prescaler for every timer
    charge_timebase timebase ( // RL23
        .clk(clk),
        .rst_n(rst_n),
        .msTick(msTick),
        .flashPhase(flashPhase)
    );

    function automatic logic [24:0] safetyLimit(input logic [1:0] sel);
        logic [24:0] lim;
        lim = 25'h1FFFFFF;
        if (sel == `TSEL_4H) begin
            lim = 25'(`SAFETY_HR_0 * `MS_PER_HR);
        end else if (sel == `TSEL_6H) begin
            lim = 25'(`SAFETY_HR_1 * `MS_PER_HR);
        end else if (sel == `TSEL_8H) begin
            lim = 25'(`SAFETY_HR_2 * `MS_PER_HR);
        end
        return lim;
    endfunction

    assign charging = (state == ST_CC) || (state == ST_CV);

    // safety timer restarts on each fast charge entry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            safetyMs <= 25'h0000000;
        end else if (next_state == ST_CC && state != ST_CC) begin
            safetyMs <= 25'h0000000; // RL1
        end else if (charging && msTick && !safetyExpired) begin
            safetyMs <= safetyMs + 25'h0000001;
        end
    end

    assign safetyExpired = (safetyTimerSel != `TSEL_OFF) // RL8
        && (safetyMs >= safetyLimit(safetyTimerSel));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preconMs <= 22'h000000;
        end else if (state != ST_PRECON) begin
            preconMs <= 22'h000000;
        end else if (msTick && !preconExpired) begin
            preconMs <= preconMs + 22'h000001;
        end
    end

    assign preconExpired = preconTimerEnable
        && (preconMs >= 22'(`PRECON_MIN * `MS_PER_MIN));

    // transient load dips shorter than the filter never terminate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eocMs <= 4'h0;
        end else if (state != ST_CV || !belowEocRatio) begin
            eocMs <= 4'h0; // RL7
        end else if (msTick && !eocQualified) begin
            eocMs <= eocMs + 4'h1;
        end
    end

    // first tick may land anywhere in the first ms, one more guarantees it
    assign eocQualified = (eocMs >= 4'(`EOC_FILTER_TICKS + 1)); // RL7

    // no-recharge latch: cleared by removal, power or program pin cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latchedOff <= 1'b0;
        end else if (state == ST_CV && eocQualified && !rechargeEnable) begin
            // set wins; a clearing level is still there next cycle
            latchedOff <= 1'b1; // RL10
        end else if (!supplyOk || !batteryPresent || programOpen) begin
            latchedOff <= 1'b0; // RL11
        end
    end

    // reconnect must be seen for two cycles before a restart
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prevProgramOpen <= 1'b0;
        end else begin
            prevProgramOpen <= programOpen;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_SHUTDOWN: begin
                next_state = ST_STANDBY;
            end
            ST_STANDBY: begin
                if (batteryPresent && !programOpen && !prevProgramOpen
                    && !latchedOff) begin
                    next_state = belowShort ? ST_SHORT : ST_PRECON;
                end
            end
            ST_SHORT: begin
                if (aboveShortHyst) begin
                    next_state = ST_PRECON; // RL17
                end
            end
            ST_PRECON: begin
                if (belowShort) begin
                    next_state = ST_SHORT; // RL16
                end else if (!belowPrecon || !preconEnable) begin
                    next_state = ST_CC; // RL19
                end else if (preconExpired) begin
                    next_state = ST_PRE_FAULT; // RL20
                end
            end
            ST_CC: begin
                if (belowShort) begin
                    next_state = ST_SHORT; // RL16
                end else if (atRegulation) begin
                    next_state = ST_CV; // RL2
                end else if (safetyExpired) begin
                    next_state = ST_TIMER_FAULT; // RL3
                end
            end
            ST_CV: begin
                if (eocQualified || safetyExpired) begin // RL6
                    next_state = rechargeEnable ? ST_DONE : ST_STANDBY; // RL10
                end
            end
            ST_DONE: begin
                if (belowRecharge) begin
                    next_state = ST_PRECON; // RL9
                end
            end
            ST_TEMP_FAULT: begin
                if (dieCooled) begin
                    next_state = ST_STANDBY; // RL12
                end
            end
            ST_TIMER_FAULT, ST_PRE_FAULT: begin
                next_state = state; // RL4
            end
            default: begin
                next_state = ST_SHUTDOWN;
            end
        endcase
        // overriding conditions in priority order
        if (!batteryPresent && (state == ST_TIMER_FAULT || state == ST_PRE_FAULT
            || state == ST_SHORT || state == ST_PRECON || charging
            || state == ST_DONE)) begin
            next_state = ST_STANDBY; // RL4
        end
        if (programOpen && state != ST_TEMP_FAULT) begin
            next_state = ST_STANDBY; // RL21
        end
        // hot die shows its fault even on leaving shutdown
        if (dieHot) begin
            next_state = ST_TEMP_FAULT; // RL24
        end
        if (!supplyOk) begin
            next_state = ST_SHUTDOWN; // RL22
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_SHUTDOWN;
        end else begin
            state <= next_state;
        end
    end

    // current command follows state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            currentMode <= CUR_OFF;
        end else begin
            case (next_state)
                ST_SHORT: currentMode <= CUR_SHORT; // RL16
                ST_PRECON: currentMode <= CUR_PRECON; // RL19
                ST_CC: currentMode <= CUR_FAST;
                ST_CV: currentMode <= CUR_CV;
                default: currentMode <= CUR_OFF; // RL12
            endcase
        end
    end

    // foldback only meaningful while current flows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thermalFoldback <= 1'b0;
        end else begin
            thermalFoldback <= dieRegulating && (next_state == ST_PRECON
                || next_state == ST_CC || next_state == ST_CV); // RL18
        end
    end

    // option straps sampled every cycle after release, following the pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vregTarget <= VREG_8V2;
            eocTarget <= EOC_5;
        end else begin
            vregTarget <= vregSel; // RL5
            eocTarget <= eocSel;
        end
    end

    // open drain: output level is always low, enable selects pull
    assign statusOut = 1'b0; // RL13
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statusOe <= 1'b0;
        end else begin
            case (next_state)
                ST_PRECON, ST_CC, ST_CV: statusOe <= 1'b1; // RL14
                // steady variant leaves the pin released in every fault
                ST_TEMP_FAULT, ST_TIMER_FAULT, ST_PRE_FAULT:
                    statusOe <= flashType && flashPhase; // RL15
                default: statusOe <= 1'b0; // RL14
            endcase
        end
    end
endmodule

// >>> tb/charge_seq_properties.sv
/*
 * Concurrent checks on the charge sequencer ports, bound into it.
 * Assumes one clock domain and synchronous active-low reset.
 */
`timescale 1ns/1ns
module charge_seq_props
    import charge_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supplyOk,
    input wire logic batteryPresent,
    input wire logic programOpen,
    input wire logic aboveShortHyst,
    input wire logic atRegulation,
    input wire logic belowEocRatio,
    input wire logic dieHot,
    input wire logic [1:0] safetyTimerSel,
    input wire logic flashType,
    input wire charge_state_t state,
    input wire current_mode_t currentMode,
    input wire logic statusOut,
    input wire logic statusOe
);
    localparam int EOC_MIN = 24999;
    logic [15:0] lowRun;
    always_ff @(posedge clk) begin
        if (!rst_n || !belowEocRatio) begin
            lowRun <= 16'h0000;
        end else if (lowRun != 16'hFFFF) begin
            lowRun <= lowRun + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // timer expiry also ends CV, so only judged with the timer off
    sequence cvEnds;
        $past(state) == ST_CV && (state == ST_DONE || state == ST_STANDBY)
            && $past(!programOpen && batteryPresent && safetyTimerSel == 2'h3);
    endsequence
    sequence shortLeft;
        $past(state) == ST_SHORT && state == ST_PRECON;
    endsequence
    a_eoc_filter_hold: assert property (cvEnds |-> $past(lowRun) >= EOC_MIN)
        else $error("charge ended before low current persisted");
    a_short_exit_hyst: assert property (shortLeft |-> $past(aboveShortHyst))
        else $error("short hold left without hysteresis");
    a_cv_after_reg: assert property ($past(state) == ST_CC && state == ST_CV
        |-> $past(atRegulation))
        else $error("fast charge left before regulation level");
    a_supply_loss_off: assert property (!supplyOk |=> state == ST_SHUTDOWN)
        else $error("no shutdown on supply loss");
    a_hot_temp_fault: assert property (supplyOk && dieHot |=> state == ST_TEMP_FAULT)
        else $error("no temperature fault when hot");
    a_open_current_program_pin_stand: assert property (supplyOk && !dieHot && programOpen
        && state != ST_TEMP_FAULT |=> state == ST_STANDBY)
        else $error("open program pin did not hold standby");
    a_pin_only_low: assert property (statusOut == 1'b0)
        else $error("status pin driven high");
    a_charge_pulls_low: assert property (state inside {ST_PRECON, ST_CC, ST_CV}
        |-> statusOe)
        else $error("status released while charging");
    a_idle_released: assert property (state inside {ST_SHUTDOWN, ST_STANDBY, ST_DONE}
        |-> !statusOe)
        else $error("status pulled low while idle");
    a_fault_no_flash: assert property (!flashType
        && state inside {ST_TEMP_FAULT, ST_TIMER_FAULT, ST_PRE_FAULT} |-> !statusOe)
        else $error("steady variant pulled status in fault");
    a_short_trickle: assert property (state == ST_SHORT |-> currentMode == CUR_SHORT)
        else $error("short hold not on recovery current");
endmodule
bind charge_sequencer charge_seq_props charge_seq_props_inst (.clk, .rst_n, .supplyOk,
    .batteryPresent, .programOpen, .aboveShortHyst, .atRegulation, .belowEocRatio, .dieHot,
    .safetyTimerSel, .flashType, .state, .currentMode, .statusOut, .statusOe);

// >>> tb/status_led_model.sv
/*
 * Status pin load: pull-up plus LED seen by a host input.
 * Assumes the open-drain split into data and enable.
 */
`timescale 1ns/1ns
module status_led_model (
    input wire logic statusOut,
    input wire logic statusOe,
    output logic pinLevel,
    output logic ledOn
);
    // released pin floats up through the resistor
    assign pinLevel = statusOe ? statusOut : 1'b1;
    assign ledOn = !pinLevel;
endmodule

// >>> tb/testbench.sv
/*
 * Self-checking bench for the charge sequencer and its status load.
 * Assumes the 25 MHz clock and no shortened timer counts.
 */
`timescale 1ns/1ns
module testbench;
    import charge_seq_pkg::*;
    logic clk = 0, rst_n = 0, supplyOk = 0, batteryPresent = 0, programOpen = 0;
    logic belowShort = 0, aboveShortHyst = 0, belowPrecon = 0, atRegulation = 0;
    logic belowRecharge = 0, belowEocRatio = 0, dieHot = 0, dieCooled = 0, dieRegulating = 0;
    vreg_sel_t vregSel = VREG_8V2, vregTarget;
    eoc_sel_t eocSel = EOC_5, eocTarget;
    charge_state_t state;
    current_mode_t currentMode;
    logic thermalFoldback, statusOut, statusOe, pinLevel;
    int bad_count = 0, checked = 0, cycles = 0, n;
    // supply,batt,progOpen,short,shortHyst,precon,atReg,recharge,hot,cooled
    logic [9:0] rowIn [13] = '{10'h000, 10'h200, 10'h354, 10'h314, 10'h334, 10'h320,
        10'h328, 10'h32A, 10'h328, 10'h3A9, 10'h334, 10'h320, 10'h328};
    logic [6:0] rowOut [13] = '{{ST_SHUTDOWN, CUR_OFF}, {ST_STANDBY, CUR_OFF},
        {ST_SHORT, CUR_SHORT}, {ST_SHORT, CUR_SHORT}, {ST_PRECON, CUR_PRECON},
        {ST_CC, CUR_FAST}, {ST_CV, CUR_CV}, {ST_TEMP_FAULT, CUR_OFF},
        {ST_TEMP_FAULT, CUR_OFF}, {ST_STANDBY, CUR_OFF}, {ST_PRECON, CUR_PRECON},
        {ST_CC, CUR_FAST}, {ST_CV, CUR_CV}};
    charge_sequencer charge_sequencer_inst (.clk, .rst_n, .supplyOk, .batteryPresent,
        .programOpen, .belowShort, .aboveShortHyst, .belowPrecon, .atRegulation,
        .belowRecharge, .belowEocRatio, .dieHot, .dieCooled, .dieRegulating, .vregSel,
        .eocSel, .safetyTimerSel(2'h3), .preconEnable(1'b1), .preconTimerEnable(1'b0),
        .rechargeEnable(1'b0), .flashType(1'b0), .state, .currentMode, .thermalFoldback,
        .vregTarget, .eocTarget, .statusOut, .statusOe);
    status_led_model status_led_model_inst (.statusOut, .statusOe, .pinLevel, .ledOn());
    initial begin
        forever #20 clk = ~clk;
    end
    task chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task wait_cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task complete_run();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 75000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        wait_cyc(20);
        chk(state === ST_SHUTDOWN && statusOe === 1'b0 && currentMode === CUR_OFF, "reset");
        @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            vregSel <= vreg_sel_t'(i);
            eocSel <= eoc_sel_t'(3 - i);
            wait_cyc(3);
            chk(vregTarget === vreg_sel_t'(i)
                && eocTarget === eoc_sel_t'(3 - i), "strap");
        end
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            {supplyOk, batteryPresent, programOpen, belowShort, aboveShortHyst, belowPrecon,
                atRegulation, belowRecharge, dieHot, dieCooled} <= rowIn[i];
            wait_cyc(6);
            chk(state === rowOut[i][6:3]
                && currentMode === rowOut[i][2:0], "walk");
        end
        chk(pinLevel === 1'b0, "pin not low while charging");
        $display("walk done");
        @(posedge clk);
        dieRegulating <= 1;
        belowEocRatio <= 1;
        wait_cyc(3);
        chk(thermalFoldback === 1'b1, "no foldback");
        // a dip shorter than the filter must not end the cycle
        wait_cyc(20000);
        @(posedge clk);
        belowEocRatio <= 0;
        wait_cyc(5);
        chk(state === ST_CV, "short dip terminated");
        @(posedge clk);
        belowEocRatio <= 1;
        n = 0;
        while (state !== ST_STANDBY && n < 60000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n >= 25000 && n <= 50010, "filter length");
        chk(state === ST_STANDBY && pinLevel === 1'b1, "no standby after end");
        @(posedge clk);
        belowEocRatio <= 0;
        dieRegulating <= 0;
        belowRecharge <= 1;
        wait_cyc(20);
        chk(state === ST_STANDBY, "restart without cycle");
        @(posedge clk);
        programOpen <= 1;
        wait_cyc(4);
        @(posedge clk);
        programOpen <= 0;
        wait_cyc(10);
        chk(state !== ST_STANDBY && statusOe === 1'b1, "no restart after reconnect");
        $display("termination done");
        @(posedge clk);
        rst_n <= 0;
        wait_cyc(2);
        chk(state === ST_SHUTDOWN && statusOe === 1'b0, "mid-run reset");
        @(posedge clk);
        rst_n <= 1;
        wait_cyc(1);
        chk(state === ST_STANDBY && statusOe === 1'b0, "first edge after release");
        wait_cyc(1);
        chk(state === ST_PRECON && currentMode === CUR_PRECON, "restart after release");
        $display("reset done");
        complete_run();
    end
endmodule
